// ===== cmd_streamer.sv
// Command streamer model that hands command words to the walker front end
`timescale 1ns/10ps
module cmd_streamer
	import media_walker_pkg::*;
(
	input  wire logic    sys_clk,
	input  wire logic    cmd_ready,
	output cmd_word_type cmd,
	output logic         cmd_valid
);
	logic late = 1'b0;

	initial
	begin
		cmd = '0;
		cmd_valid = 1'b0;
	end

	// Caller owns the drain, select, state, primitive order; this keeps the handshake
	task automatic send(input cmd_op_type op, input logic [31:0] a0, input logic [31:0] a1);
		int n;
		n = 0;
		// One idle edge between words, so valid is never lowered and raised in one step
		@(posedge sys_clk);
		#1;
		cmd.op = op;
		cmd.arg0 = a0;
		cmd.arg1 = a1;
		cmd_valid = 1'b1;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (cmd_ready !== 1'b1 && n < 200);
		if (cmd_ready !== 1'b1)
			late = 1'b1;
		#1;
		cmd_valid = 1'b0;
		// A released word is inverted so no stale value can pass for a fresh one
		cmd = cmd_word_type'(~cmd);
	endtask
endmodule

// ===== media_command_walker.sv
// Media command front end: command sequencing, fences, handle rebuild and the loop walker
//
// Overview of operation
// - State fence drains front end and spawner
// - Latest state command of a type wins
// - Front end config rebuilds all return buffer handles
// - Fetches bounded by indirect and dynamic windows
// - Walker runs two global, three local loops
// - Each walker: resolution, start, outer, inner steps
// - Inner loop dual and extra steps; repel, attract stored but unused
// - Output coordinate is global plus local position
// - Dual mode alternates two half-walks
// - Middle loop bounded by extra-step count
`timescale 1ns/10ps
module media_command_walker
	import media_walker_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire cmd_word_type     cmd,
	input  wire logic             cmd_valid,
	output logic                  cmd_ready,
	input  wire logic             front_end_idle,
	input  wire logic             spawner_idle,
	input  wire logic [31:0]      fetch_addr,
	input  wire logic             fetch_dynamic,
	output logic                  fetch_ok,
	output logic                  handle_rebuild,
	output logic [7:0]            handle_count,
	output logic [7:0]            handle_length,
	output logic                  sequence_error,
	output logic                  arbitration_on,
	output logic [31:0]           barrier_watermark,
	output logic                  dispatch_valid,
	input  wire logic             dispatch_ready,
	output xy_type                dispatch_xy,
	output logic                  walk_busy
);

	typedef enum logic [1:0] {st_idle, st_fence, st_walk} main_state_type;

	main_state_type   state_q, state_d;
	logic [3:0]       step_q, step_d;
	logic [2:0]       seen_q, seen_d;
	fetch_window_type ind_win_q, ind_win_d, dyn_win_q, dyn_win_d;
	logic [7:0]       hcnt_q, hcnt_d, hlen_q, hlen_d;
	logic             rebuild_q, rebuild_d, err_q, err_d, arb_q, arb_d;
	logic [31:0]      wm_q, wm_d;
	walk_cfg_type     cfg_q, cfg_d;
	xy_type           g_outer_q, g_outer_d, g_inner_q, g_inner_d;
	xy_type           l_outer_q, l_outer_d, l_inner_q, l_inner_d;
	logic [3:0]       mid_q, mid_d;
	logic             half_q, half_d;
	xy_type           out_q, out_d;
	logic             outv_q, outv_d;

	logic accept;
	logic is_state_cmd;

	function automatic logic in_box(input xy_type p, input xy_type box);
		in_box = p.x >= 0 && p.y >= 0 && p.x < box.x && p.y < box.y;
	endfunction

	function automatic xy_type add_xy(input xy_type a, input xy_type b);
		add_xy.x = a.x + b.x;
		add_xy.y = a.y + b.y;
	endfunction

	// One signed nibble per component: a 32-bit word cannot carry full fields, so sizes stop at 7
	function automatic xy_type nib_xy(input logic [7:0] w);
		nib_xy.x = COORD_W'(signed'(w[7:4]));
		nib_xy.y = COORD_W'(signed'(w[3:0]));
	endfunction

	function automatic loop_cfg_type unpack_loop(input logic [31:0] w);
		unpack_loop.res        = nib_xy(w[31:24]);
		unpack_loop.start      = nib_xy(w[23:16]);
		unpack_loop.outer_step = nib_xy(w[15:8]);
		unpack_loop.inner_step = nib_xy(w[7:0]);
	endfunction

	assign cmd_ready = (state_q == st_idle) && !outv_q;
	assign accept    = cmd_valid && cmd_ready;
	assign is_state_cmd = cmd.op inside {base_address_cmd, system_routine_ptr_cmd,
		front_end_config_cmd, constant_load_cmd, descriptor_load_cmd,
		barrier_group_config_cmd};

	// Window picked by fetch_dynamic checked combinationally so a fetch is never issued a cycle late
	always_comb
	begin
		if (fetch_dynamic)
			fetch_ok = fetch_addr >= dyn_win_q.lo && fetch_addr < dyn_win_q.hi;
		else
			fetch_ok = fetch_addr >= ind_win_q.lo && fetch_addr < ind_win_q.hi;
	end

	always_comb
	begin
		state_d   = state_q;
		step_d    = step_q;
		seen_d    = seen_q;
		ind_win_d = ind_win_q;
		dyn_win_d = dyn_win_q;
		hcnt_d    = hcnt_q;
		hlen_d    = hlen_q;
		rebuild_d = 1'b0;
		err_d     = err_q;
		arb_d     = arb_q;
		wm_d      = wm_q;
		cfg_d     = cfg_q;
		g_outer_d = g_outer_q;
		g_inner_d = g_inner_q;
		l_outer_d = l_outer_q;
		l_inner_d = l_inner_q;
		mid_d     = mid_q;
		half_d    = half_q;
		out_d     = out_q;
		outv_d    = outv_q && !dispatch_ready;
		unique case (state_q)
			st_idle:
			if (accept)
			begin
				unique case (cmd.op)
					pipe_drain_cmd:
					begin
						step_d = 4'h1;
						seen_d = 3'b000;
					end
					pipeline_select_cmd:
						step_d = 4'h2;
					base_address_cmd:
					begin
						ind_win_d = '{lo: cmd.arg0, hi: cmd.arg1};
						dyn_win_d = '{lo: cmd.arg0, hi: cmd.arg1};
						seen_d[0] = 1'b1;
						step_d    = 4'h3;
					end
					front_end_config_cmd:
					begin
						hcnt_d    = cmd.arg0[7:0];
						hlen_d    = cmd.arg0[15:8];
						rebuild_d = 1'b1;
						seen_d[1] = 1'b1;
					end
					descriptor_load_cmd:
					begin
						dyn_win_d = '{lo: cmd.arg0, hi: cmd.arg1};
						seen_d[2] = 1'b1;
					end
					state_fence_cmd:
					begin
						wm_d    = cmd.arg0;
						state_d = st_fence;
					end
					arbitration_toggle_cmd:
						arb_d = cmd.arg0[0];
					walk_cmd:
					begin
						// A start word only launches, so it never overwrites the stored set-up
						if (!cmd.arg1[31] && cmd.arg1[0])
							cfg_d.glb = unpack_loop(cmd.arg0);
						else if (!cmd.arg1[31])
						begin
							cfg_d.loc         = unpack_loop(cmd.arg0);
							cfg_d.dual        = cmd.arg1[1];
							cfg_d.repel       = cmd.arg1[2];
							cfg_d.attract     = cmd.arg1[3];
							cfg_d.extra_steps = cmd.arg1[7:4];
							cfg_d.middle_step = nib_xy(cmd.arg1[15:8]);
						end
						if (cmd.arg1[31] && seen_q == 3'b111)
						begin
							g_outer_d = cfg_q.glb.start;
							g_inner_d = cfg_q.glb.start;
							l_outer_d = cfg_q.loc.start;
							l_inner_d = cfg_q.loc.start;
							mid_d     = STEP_NONE;
							half_d    = 1'b0;
							state_d   = st_walk;
						end
					end
					default:
					begin
					end
				endcase
				// A state command after primitives without a drain or pipeline select is flagged, but still executed
				if (is_state_cmd && step_q == 4'h4)
					err_d = 1'b1;
				if (cmd.op inside {media_item_cmd, persistent_thread_item_cmd, walk_cmd})
				begin
					if (seen_q != 3'b111)
						err_d = 1'b1;
					step_d = 4'h4;
				end
				if (cmd.op != base_address_cmd && is_state_cmd && !seen_q[0])
					err_d = 1'b1;
			end
			st_fence:
				if (front_end_idle && spawner_idle)
					state_d = st_idle;
			st_walk:
			if (!outv_q || dispatch_ready)
			begin
				out_d  = add_xy(g_inner_q, half_q ? l_outer_q : l_inner_q);
				outv_d = 1'b1;
				if (cfg_q.dual)
					half_d = !half_q;
				l_inner_d = add_xy(l_inner_q, cfg_q.loc.inner_step);
				if (!in_box(add_xy(l_inner_q, cfg_q.loc.inner_step), cfg_q.loc.res))
				begin
					if (mid_q < cfg_q.extra_steps)
					begin
						mid_d     = mid_q + 4'h1;
						l_inner_d = add_xy(l_outer_q, cfg_q.middle_step);
						l_outer_d = add_xy(l_outer_q, cfg_q.middle_step);
					end
					else if (in_box(add_xy(l_outer_q, cfg_q.loc.outer_step), cfg_q.loc.res))
					begin
						mid_d     = STEP_NONE;
						l_outer_d = add_xy(l_outer_q, cfg_q.loc.outer_step);
						l_inner_d = add_xy(l_outer_q, cfg_q.loc.outer_step);
					end
					else
					begin
						mid_d     = STEP_NONE;
						l_outer_d = cfg_q.loc.start;
						l_inner_d = cfg_q.loc.start;
						g_inner_d = add_xy(g_inner_q, cfg_q.glb.inner_step);
						if (!in_box(add_xy(g_inner_q, cfg_q.glb.inner_step), cfg_q.glb.res))
						begin
							g_outer_d = add_xy(g_outer_q, cfg_q.glb.outer_step);
							g_inner_d = add_xy(g_outer_q, cfg_q.glb.outer_step);
							if (!in_box(add_xy(g_outer_q, cfg_q.glb.outer_step),
								cfg_q.glb.res))
								state_d = st_idle;
						end
					end
				end
			end
			default:
				state_d = st_idle;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state_q   <= st_idle;
			step_q    <= STEP_NONE;
			seen_q    <= 3'b000;
			ind_win_q <= '0;
			dyn_win_q <= '0;
			hcnt_q    <= HANDLE_COUNT_RST;
			hlen_q    <= HANDLE_LENGTH_RST;
			rebuild_q <= 1'b0;
			err_q     <= 1'b0;
			arb_q     <= 1'b1;
			wm_q      <= '0;
			cfg_q     <= '0;
			g_outer_q <= '0;
			g_inner_q <= '0;
			l_outer_q <= '0;
			l_inner_q <= '0;
			mid_q     <= STEP_NONE;
			half_q    <= 1'b0;
			out_q     <= '0;
			outv_q    <= 1'b0;
		end
		else
		begin
			state_q   <= state_d;
			step_q    <= step_d;
			seen_q    <= seen_d;
			ind_win_q <= ind_win_d;
			dyn_win_q <= dyn_win_d;
			hcnt_q    <= hcnt_d;
			hlen_q    <= hlen_d;
			rebuild_q <= rebuild_d;
			err_q     <= err_d;
			arb_q     <= arb_d;
			wm_q      <= wm_d;
			cfg_q     <= cfg_d;
			g_outer_q <= g_outer_d;
			g_inner_q <= g_inner_d;
			l_outer_q <= l_outer_d;
			l_inner_q <= l_inner_d;
			mid_q     <= mid_d;
			half_q    <= half_d;
			out_q     <= out_d;
			outv_q    <= outv_d;
		end
	end

	assign handle_rebuild    = rebuild_q;
	assign handle_count      = hcnt_q;
	assign handle_length     = hlen_q;
	assign sequence_error    = err_q;
	assign arbitration_on    = arb_q;
	assign barrier_watermark = wm_q;
	assign dispatch_valid    = outv_q;
	assign dispatch_xy       = out_q;
	assign walk_busy         = state_q == st_walk;

	sequence fence_taken;
		accept && cmd.op == state_fence_cmd;
	endsequence

	a_fence_blocks_cmds: assert property (@(posedge sys_clk) disable iff (rst)
		fence_taken ##1 !(front_end_idle && spawner_idle) |-> !cmd_ready)
		else $error("command taken during fence drain");
	a_rebuild_pulse: assert property (@(posedge sys_clk) disable iff (rst)
		accept && cmd.op == front_end_config_cmd |=> handle_rebuild
		&& handle_count == $past(cmd.arg0[7:0]))
		else $error("handle rebuild missing");
	a_latest_wins: assert property (@(posedge sys_clk) disable iff (rst)
		accept && cmd.op == front_end_config_cmd |=> handle_length == $past(cmd.arg0[15:8]))
		else $error("front end config not replaced");
	a_dispatch_hold: assert property (@(posedge sys_clk) disable iff (rst)
		dispatch_valid && !dispatch_ready |=> dispatch_valid && $stable(dispatch_xy))
		else $error("dispatch dropped while stalled");
	a_dual_alternate: assert property (@(posedge sys_clk) disable iff (rst)
		state_q == st_walk && cfg_q.dual && !outv_q |=> half_q != $past(half_q))
		else $error("dual mode did not alternate");
	a_middle_bound: assert property (@(posedge sys_clk) disable iff (rst)
		mid_q <= cfg_q.extra_steps || state_q != st_walk)
		else $error("middle loop exceeded extra steps");
	a_window_check: assert property (@(posedge sys_clk) disable iff (rst)
		fetch_ok |-> fetch_addr < (fetch_dynamic ? dyn_win_q.hi : ind_win_q.hi))
		else $error("fetch outside window");
	a_coord_sum: assert property (@(posedge sys_clk) disable iff (rst)
		state_q == st_walk && !outv_q && !cfg_q.dual |=> dispatch_valid
		&& dispatch_xy == add_xy($past(g_inner_q), $past(l_inner_q)))
		else $error("coordinate not global plus local");

endmodule

// ===== media_walker_pkg.sv
// Package of commands, field layouts and constants for the media command walker
package media_walker_pkg;

	localparam int COORD_W = 12;

	typedef enum logic [3:0] {
		cmd_nop,
		pipe_drain_cmd,
		pipeline_select_cmd,
		base_address_cmd,
		system_routine_ptr_cmd,
		front_end_config_cmd,
		constant_load_cmd,
		descriptor_load_cmd,
		barrier_group_config_cmd,
		state_fence_cmd,
		arbitration_toggle_cmd,
		media_item_cmd,
		persistent_thread_item_cmd,
		walk_cmd,
		compute_item_cmd,
		compute_walk_cmd
	} cmd_op_type;

	typedef struct packed {
		cmd_op_type  op;
		logic [31:0] arg0;
		logic [31:0] arg1;
	} cmd_word_type;

	typedef struct packed {
		logic signed [COORD_W-1:0] x;
		logic signed [COORD_W-1:0] y;
	} xy_type;

	typedef struct packed {
		xy_type res;
		xy_type start;
		xy_type outer_step;
		xy_type inner_step;
	} loop_cfg_type;

	typedef struct packed {
		loop_cfg_type glb;
		loop_cfg_type loc;
		logic         dual;
		logic         repel;
		logic         attract;
		logic [3:0]   extra_steps;
		xy_type       middle_step;
	} walk_cfg_type;

	typedef struct packed {
		logic [31:0] lo;
		logic [31:0] hi;
	} fetch_window_type;

	localparam logic [7:0] HANDLE_COUNT_RST  = 8'h00;
	localparam logic [7:0] HANDLE_LENGTH_RST = 8'h00;
	localparam logic [3:0] STEP_NONE         = 4'h0;

endpackage

// ===== tb_top.sv
// Self-checking testbench for the media command walker
`timescale 1ns/10ps
module tb_top;
	import media_walker_pkg::*;
	logic         sys_clk = 1'b0;
	logic         rst = 1'b1;
	cmd_word_type cmd;
	logic         cmd_valid;
	logic         cmd_ready;
	logic         front_end_idle;
	logic         spawner_idle;
	logic [31:0]  fetch_addr;
	logic         fetch_dynamic;
	logic         fetch_ok;
	logic         handle_rebuild;
	logic [7:0]   handle_count;
	logic [7:0]   handle_length;
	logic         sequence_error;
	logic         arbitration_on;
	logic [31:0]  barrier_watermark;
	logic         dispatch_valid;
	logic         dispatch_ready;
	xy_type       dispatch_xy;
	logic         walk_busy;
	xy_type       held_xy;
	int           mismatches = 0;
	int           n_compared = 0;

	always #10 sys_clk = ~sys_clk;

	cmd_streamer cs (.sys_clk(sys_clk), .cmd_ready(cmd_ready), .cmd(cmd), .cmd_valid(cmd_valid));

	media_command_walker dut (.sys_clk(sys_clk), .rst(rst), .cmd(cmd), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .front_end_idle(front_end_idle), .spawner_idle(spawner_idle),
		.fetch_addr(fetch_addr), .fetch_dynamic(fetch_dynamic), .fetch_ok(fetch_ok),
		.handle_rebuild(handle_rebuild), .handle_count(handle_count),
		.handle_length(handle_length), .sequence_error(sequence_error),
		.arbitration_on(arbitration_on), .barrier_watermark(barrier_watermark),
		.dispatch_valid(dispatch_valid), .dispatch_ready(dispatch_ready),
		.dispatch_xy(dispatch_xy), .walk_busy(walk_busy));

	task automatic finish_test();
		$display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic send(input cmd_op_type op, input logic [31:0] a0, input logic [31:0] a1);
		cs.send(op, a0, a1);
		if (cs.late)
		begin
			mismatches++;
			finish_test();
		end
	endtask

	task automatic do_reset();
		cyc(1);
		rst = 1'b1;
		cyc(10);
		rst = 1'b0;
	endtask

	task automatic setup();
		send(pipe_drain_cmd, 32'h0, 32'h0);
		send(pipeline_select_cmd, 32'h0, 32'h0);
		send(base_address_cmd, 32'h0000_0100, 32'h0000_0200);
		send(front_end_config_cmd, 32'h0000_1234, 32'h0);
		send(front_end_config_cmd, 32'h0000_5678, 32'h0);
		check("rebuild", handle_rebuild, 1);
		check("count", handle_count, 8'h78);
		check("length", handle_length, 8'h56);
		cyc(1);
		check("rebuild end", handle_rebuild, 0);
		send(descriptor_load_cmd, 32'h0000_0300, 32'h0000_0400);
	endtask

	task automatic t_reset();
		check("ready", cmd_ready, 1);
		check("arb", arbitration_on, 1);
		check("seq err", sequence_error, 0);
		check("valid", dispatch_valid, 0);
		check("busy", walk_busy, 0);
		send(front_end_config_cmd, 32'h0, 32'h0);
		check("state first", sequence_error, 1);
		do_reset();
	endtask

	task automatic t_state();
		logic [31:0] addr [7] = '{32'h100, 32'h1ff, 32'h200, 32'hff, 32'h300, 32'h3ff, 32'h400};
		logic        dyn  [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
		logic        exp  [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
		setup();
		check("seq ok", sequence_error, 0);
		for (int i = 0; i < 7; i++)
		begin
			fetch_addr = addr[i];
			fetch_dynamic = dyn[i];
			cyc(1);
			check("fetch", fetch_ok, exp[i]);
		end
	endtask

	task automatic t_fence();
		front_end_idle = 1'b0;
		spawner_idle = 1'b0;
		send(state_fence_cmd, 32'h0000_abcd, 32'h0);
		check("watermark", barrier_watermark, 32'h0000_abcd);
		cyc(3);
		check("fence hold", cmd_ready, 0);
		front_end_idle = 1'b1;
		cyc(2);
		check("fence half", cmd_ready, 0);
		spawner_idle = 1'b1;
		for (int i = 0; i < 10 && cmd_ready !== 1'b1; i++)
			cyc(1);
		check("fence done", cmd_ready, 1);
		if (cmd_ready !== 1'b1)
			finish_test();
		send(arbitration_toggle_cmd, 32'h0, 32'h0);
		check("arb off", arbitration_on, 0);
		send(arbitration_toggle_cmd, 32'h1, 32'h0);
		check("arb on", arbitration_on, 1);
	endtask

	task automatic t_drain();
		send(media_item_cmd, 32'h0, 32'h0);
		send(pipe_drain_cmd, 32'h0, 32'h0);
		send(base_address_cmd, 32'h0000_0100, 32'h0000_0200);
		check("drained", sequence_error, 0);
		send(front_end_config_cmd, 32'h0000_0000, 32'h0);
		send(descriptor_load_cmd, 32'h0000_0300, 32'h0000_0400);
		send(media_item_cmd, 32'h0, 32'h0);
		check("primitive ok", sequence_error, 0);
		send(base_address_cmd, 32'h0000_0100, 32'h0000_0200);
		check("undrained", sequence_error, 1);
		do_reset();
	endtask

	task automatic t_walk();
		logic [23:0] want [8] = '{24'h000000, 24'h001000, 24'h000001, 24'h001001,
			24'h002000, 24'h003000, 24'h002001, 24'h003001};
		int          n = 0;
		setup();
		dispatch_ready = 1'b0;
		send(walk_cmd, 32'h4200_0220, 32'h0000_0001);
		send(walk_cmd, 32'h2200_0110, 32'h0000_0000);
		send(walk_cmd, 32'h0000_0000, 32'h8000_0000);
		for (int i = 0; i < 200 && dispatch_valid !== 1'b1; i++)
			cyc(1);
		check("dispatch", dispatch_valid, 1);
		if (dispatch_valid !== 1'b1)
			finish_test();
		held_xy = dispatch_xy;
		cyc(3);
		check("stall valid", dispatch_valid, 1);
		check("stall xy", dispatch_xy, held_xy);
		check("walk refuse", cmd_ready, 0);
		dispatch_ready = 1'b1;
		for (int i = 0; i < 40 && (dispatch_valid === 1'b1 || walk_busy === 1'b1); i++)
		begin
			if (dispatch_valid === 1'b1)
			begin
				if (n < 8)
					check("walk xy", dispatch_xy, want[n]);
				n++;
			end
			cyc(1);
		end
		check("walk count", n, 8);
		check("walk end", walk_busy, 0);
		if (walk_busy !== 1'b0)
			finish_test();
		check("ready after", cmd_ready, 1);
		check("walk seq", sequence_error, 0);
	endtask

	task automatic t_dual();
		logic [23:0] want [4] = '{24'h000000, 24'h000000, 24'h000001, 24'h000001};
		int          n = 0;
		send(walk_cmd, 32'h1100_0110, 32'h0000_0001);
		send(walk_cmd, 32'h2200_0110, 32'h0000_0112);
		send(walk_cmd, 32'h0000_0000, 32'h8000_0000);
		for (int i = 0; i < 40 && (dispatch_valid === 1'b1 || walk_busy === 1'b1); i++)
		begin
			if (dispatch_valid === 1'b1)
			begin
				if (n < 4)
					check("dual xy", dispatch_xy, want[n]);
				n++;
			end
			cyc(1);
		end
		check("dual count", n, 4);
		check("dual end", walk_busy, 0);
		if (walk_busy !== 1'b0)
			finish_test();
	endtask

	initial
	begin
		front_end_idle = 1'b1;
		spawner_idle = 1'b1;
		fetch_addr = 32'h0;
		fetch_dynamic = 1'b0;
		dispatch_ready = 1'b1;
		do_reset();
		t_reset();
		t_state();
		t_fence();
		t_drain();
		t_walk();
		t_dual();
		finish_test();
	end
endmodule
